// ==== alarm_mask_consts.svh ====
// Purpose: Offsets, field positions, reset values and bus figures of the alarm mask bank
// Assumes: Register indices are word indices; byte address is four times the index
// Notes:   Definitions only, guarded against double inclusion
`ifndef ALARM_MASK_CONSTS_SVH
`define ALARM_MASK_CONSTS_SVH

// ----------------------------------------
// Register indices and bus geometry
// ----------------------------------------
`define ADDR_W 8
`define DATA_W 32
`define REG_W 24
`define IDX_W 5
`define MASK_IDX 5'h12
`define CTRL_IDX 5'h1C
`define FLAGS_IDX 5'h1D

// ----------------------------------------
// Field positions
// ----------------------------------------
`define PIN_STATUS_BIT 21
`define ECHO_MSB 20
`define ECHO_LSB 16
`define MASK_MSB 15
`define FLAG_W 16
`define RSVD_BIT 5
`define LOCK_WRITE_BIT 13
`define LOCK_CHECK_EN_BIT 0
`define CFG_LOCK_BIT 1

// ----------------------------------------
// Reset values and bit groups
// ----------------------------------------
`define MASK_RESET 24'h120000
`define CTRL_RESET 2'h0
`define FLAGS_RESET 16'h0000
`define FLAG_VALID 16'hFFDF
`define CTRL_W 2

`endif

// ==== alarm_mask_pkg.sv ====
// Purpose: Types shared by the alarm mask bank
// Assumes: Used by explicit scope, never imported
// Notes:   Offsets and counts live in the constants header
package alarm_mask_pkg;

    // Bus answer sequencer
    typedef enum logic {
        BUS_IDLE,
        BUS_ANSWER
    } bus_state_type;

    // One bit per mask position
    typedef logic [15:0] flag_vec_type;

endpackage

// ==== alarm_pin_sync.sv ====
// Purpose: Two flip-flop synchroniser for levels arriving from outside the clock domain
// Assumes: Input changes slowly compared with CLK_SYS
// Notes:   The first stage feeds only the second stage
`timescale 1ns/100ps

module alarm_pin_sync #(
    parameter int WIDTH = 1,
    parameter logic [WIDTH-1:0] RESET_LEVEL = '0
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic [WIDTH-1:0] async_in,
    output logic [WIDTH-1:0] sync_out
);

    logic [WIDTH-1:0] meta_reg;
    logic [WIDTH-1:0] meta_next;
    logic [WIDTH-1:0] stable_reg;
    logic [WIDTH-1:0] stable_next;

    // ----------------------------------------
    // Stage chain
    // ----------------------------------------

    // Next values: plain shift through two stages
    always_comb begin
        meta_next = async_in;
        stable_next = meta_reg;
    end

    // Registering only; reset level is a constant
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            meta_reg <= RESET_LEVEL;
            stable_reg <= RESET_LEVEL;
        end else begin
            meta_reg <= meta_next;
            stable_reg <= stable_next;
        end
    end

    assign sync_out = stable_reg;

endmodule

// ==== alarm_pin_mask_control.sv ====
// Purpose: Mask bank that decides which diagnostic flags may pull the alarm pin
// Assumes: Flag set pulses come from logic on CLK_SYS; the alarm pin is open drain, active low
// Notes:   Registers reached over an Avalon-MM slave with one wait cycle per access
//          Flag set inputs are same-clock levels; a flag other than bit 5 sets on every edge they are high
`timescale 1ns/100ps
`include "alarm_mask_consts.svh"

module alarm_pin_mask_control (
    input wire logic CLK_SYS,
    input wire logic RST,
    input wire logic [`ADDR_W-1:0] AVS_ADDRESS,
    input wire logic AVS_READ,
    input wire logic AVS_WRITE,
    input wire logic [`DATA_W-1:0] AVS_WRITEDATA,
    input wire logic [3:0] AVS_BYTEENABLE,
    output logic [`DATA_W-1:0] AVS_READDATA,
    output logic AVS_WAITREQUEST,
    input wire logic [`FLAG_W-1:0] FLAG_SET,
    output logic [`FLAG_W-1:0] FLAG_STATE,
    input wire logic ALARM_N_I,
    output logic ALARM_N_O,
    output logic ALARM_N_OE
);

    // ----------------------------------------
    // Helper functions
    // ----------------------------------------

    // Match of a byte address against a word index; out-of-range or misaligned addresses never match
    // Stray accesses never match, so they fall through to a zero answer
    function automatic logic addr_mapped(input logic [`ADDR_W-1:0] addr,
                                         input logic [`IDX_W-1:0] idx);
        logic hit;
        hit = (addr[1:0] == 2'h0) && (addr[7] == 1'b0) && (addr[6:2] == idx);
        return hit;
    endfunction

    // Bit mask of the enabled byte lanes
    function automatic logic [`DATA_W-1:0] lane_bits(input logic [3:0] be);
        logic [`DATA_W-1:0] bits;
        bits = {{8{be[3]}}, {8{be[2]}}, {8{be[1]}}, {8{be[0]}}};
        return bits;
    endfunction

    // Merge a bus word into a stored value lane by lane
    function automatic logic [`REG_W-1:0] lane_merge(input logic [`REG_W-1:0] old_val,
                                                     input logic [`DATA_W-1:0] new_val,
                                                     input logic [3:0] be);
        logic [`REG_W-1:0] res;
        res = old_val;
        for (int i = 0; i < 3; i++) begin
            if (be[i]) begin
                res[i*8 +: 8] = new_val[i*8 +: 8];
            end
        end
        return res;
    endfunction

    // Read word: pin status, index echo, then the low field
    function automatic logic [`DATA_W-1:0] read_word(input logic pin_status,
                                                     input logic [`IDX_W-1:0] idx,
                                                     input logic [`FLAG_W-1:0] low);
        logic [`DATA_W-1:0] word;
        word = 32'h0000_0000;
        word[`PIN_STATUS_BIT] = pin_status;
        word[`ECHO_MSB:`ECHO_LSB] = idx;
        word[`FLAG_W-1:0] = low;
        return word;
    endfunction

    // ----------------------------------------
    // Declarations
    // ----------------------------------------

    alarm_mask_pkg::bus_state_type bus_state_reg;
    alarm_mask_pkg::bus_state_type bus_state_next;
    logic [`DATA_W-1:0] rdata_reg;
    logic [`DATA_W-1:0] rdata_next;
    logic [`REG_W-1:0] mask_reg;
    logic [`REG_W-1:0] mask_next;
    logic [`CTRL_W-1:0] ctrl_reg;
    logic [`CTRL_W-1:0] ctrl_next;
    alarm_mask_pkg::flag_vec_type flags_reg;
    alarm_mask_pkg::flag_vec_type flags_next;
    logic alarm_reg;
    logic alarm_next;
    logic pin_level;
    logic pin_status;
    logic request;
    logic commit;
    logic hit_mask;
    logic hit_ctrl;
    logic hit_flags;
    logic cfg_locked;
    logic lock_write_event;
    logic [`REG_W-1:0] mask_written;
    logic [`FLAG_W-1:0] clear_bits;
    logic [`FLAG_W-1:0] set_bits;
    logic [`FLAG_W-1:0] unmasked;
    logic [`DATA_W-1:0] write_lanes;

    // ----------------------------------------
    // Pin level synchroniser
    // ----------------------------------------

    // Pin idles high through its pull-up, so reset to the released level
    // Other parts may share the wire, so bit 21 shows the wire, not our own drive
    alarm_pin_sync #(
        .WIDTH(1),
        .RESET_LEVEL(1'b1)
    ) u_pin_sync (
        .clk(CLK_SYS),
        .rst(RST),
        .async_in(ALARM_N_I),
        .sync_out(pin_level)
    );

    assign pin_status = ~pin_level;

    // ----------------------------------------
    // Bus request decode
    // ----------------------------------------

    // Address decode shared by read and write paths
    assign request = AVS_READ | AVS_WRITE;
    assign hit_mask = addr_mapped(AVS_ADDRESS, `MASK_IDX);
    assign hit_ctrl = addr_mapped(AVS_ADDRESS, `CTRL_IDX);
    assign hit_flags = addr_mapped(AVS_ADDRESS, `FLAGS_IDX);

    // Write lands on the edge where waitrequest is sampled low
    assign commit = AVS_WRITE && (bus_state_reg == alarm_mask_pkg::BUS_ANSWER);
    assign cfg_locked = ctrl_reg[`CFG_LOCK_BIT];

    // Waitrequest drops in the answer cycle; combinational by design
    assign AVS_WAITREQUEST = request && (bus_state_reg == alarm_mask_pkg::BUS_IDLE);

    // ----------------------------------------
    // Bus answer sequencer
    // ----------------------------------------

    // One wait cycle gives read data a full cycle to settle from a register
    // A request held past its answer edge is taken as a second access
    always_comb begin
        bus_state_next = bus_state_reg;
        rdata_next = rdata_reg;
        unique case (bus_state_reg)
            alarm_mask_pkg::BUS_IDLE: begin
                if (request) begin
                    bus_state_next = alarm_mask_pkg::BUS_ANSWER;
                    // Unmapped reads answer zero
                    rdata_next = 32'h0000_0000;
                    if (AVS_READ && hit_mask) begin
                        rdata_next = read_word(pin_status, `MASK_IDX, mask_reg[15:0]);
                    end else if (AVS_READ && hit_ctrl) begin
                        // Only two control bits are stored; the rest read zero
                        rdata_next = read_word(pin_status, `CTRL_IDX, {14'h0000, ctrl_reg});
                    end else if (AVS_READ && hit_flags) begin
                        // Sticky vector, bit positions equal to the mask positions
                        rdata_next = read_word(pin_status, `FLAGS_IDX, flags_reg);
                    end
                end
            end
            alarm_mask_pkg::BUS_ANSWER: begin
                bus_state_next = alarm_mask_pkg::BUS_IDLE;
            end
        endcase
    end

    always_ff @(posedge CLK_SYS or posedge RST) begin
        if (RST) begin
            bus_state_reg <= alarm_mask_pkg::BUS_IDLE;
            rdata_reg <= 32'h0000_0000;
        end else begin
            bus_state_reg <= bus_state_next;
            rdata_reg <= rdata_next;
        end
    end

    // Stands from the edge that opens the answer cycle until the next access loads it; a write loads zero
    assign AVS_READDATA = rdata_reg;

    // ----------------------------------------
    // Mask and control registers
    // ----------------------------------------

    // Storing the echo bits costs a few flops but keeps the reset value whole
    // Only the low sixteen bits are writable; status and echo are rebuilt on read
    assign mask_written = lane_merge(mask_reg, AVS_WRITEDATA, AVS_BYTEENABLE);

    assign lock_write_event = commit && hit_mask && cfg_locked && ctrl_reg[`LOCK_CHECK_EN_BIT];

    // Control itself stays writable while locked so software can unlock
    always_comb begin
        mask_next = mask_reg;
        ctrl_next = ctrl_reg;
        // Dropped even with the check off; only the flag depends on it
        // drop locked mask writes
        if (commit && hit_mask && !cfg_locked) begin
            // reserved bit 5 is stored as written
            mask_next[`MASK_MSB:0] = mask_written[`MASK_MSB:0];
        end
        if (commit && hit_ctrl && AVS_BYTEENABLE[0]) begin
            ctrl_next = AVS_WRITEDATA[`CTRL_W-1:0];
        end
    end

    always_ff @(posedge CLK_SYS or posedge RST) begin
        if (RST) begin
            mask_reg <= `MASK_RESET;
            ctrl_reg <= `CTRL_RESET;
        end else begin
            mask_reg <= mask_next;
            ctrl_reg <= ctrl_next;
        end
    end

    // ----------------------------------------
    // Sticky diagnostic flags
    // ----------------------------------------

    // Byte lanes of the current write as a bit mask
    assign write_lanes = lane_bits(AVS_BYTEENABLE);

    // Write-one-to-clear over the low two byte lanes
    assign clear_bits = (commit && hit_flags) ?
        (AVS_WRITEDATA[`FLAG_W-1:0] & write_lanes[`FLAG_W-1:0]) :
        16'h0000;

    // Flag sources outside this block keep their own pulses; this bank only latches
    // Locked write flag is raised here; bit 5 has no source
    always_comb begin
        set_bits = FLAG_SET & `FLAG_VALID;
        set_bits[`LOCK_WRITE_BIT] = FLAG_SET[`LOCK_WRITE_BIT] | lock_write_event;
    end

    // Set wins over a clear in the same cycle so no event is lost
    always_comb begin
        flags_next = (flags_reg & ~clear_bits) | set_bits;
    end

    always_ff @(posedge CLK_SYS or posedge RST) begin
        if (RST) begin
            flags_reg <= `FLAGS_RESET;
        end else begin
            flags_reg <= flags_next;
        end
    end

    // Flags leave straight from their register, never from the set logic
    assign FLAG_STATE = flags_reg;

    // ----------------------------------------
    // Alarm pin drive
    // ----------------------------------------

    // Masking only gates the path to the pin; the flag stays readable
    // per-bit gating
    assign unmasked = flags_reg & ~mask_reg[`MASK_MSB:0] & `FLAG_VALID;

    always_comb begin
        alarm_next = |unmasked;
    end

    // Registered so the pin never glitches during a mask write
    // Costs one cycle of alarm latency, well inside any host polling rate
    always_ff @(posedge CLK_SYS or posedge RST) begin
        if (RST) begin
            alarm_reg <= 1'b0;
        end else begin
            alarm_reg <= alarm_next;
        end
    end

    // The pin lags a set pulse by two edges: one to latch it, one to drive
    // Open drain: only ever pulls low, the enable carries the alarm
    assign ALARM_N_O = 1'b0;
    assign ALARM_N_OE = alarm_reg;

endmodule

// ==== alarm_mask_sva.sv ====
// Purpose: Port checks of the alarm mask bank
// Assumes: One clock domain, RST active high
// Notes:   Attached by bind from the bench
`timescale 1ns/100ps
`include "alarm_mask_consts.svh"
module alarm_mask_sva (
    input wire logic CLK_SYS,
    input wire logic RST,
    input wire logic [`ADDR_W-1:0] AVS_ADDRESS,
    input wire logic AVS_READ,
    input wire logic AVS_WRITE,
    input wire logic [`DATA_W-1:0] AVS_READDATA,
    input wire logic AVS_WAITREQUEST,
    input wire logic [`FLAG_W-1:0] FLAG_SET,
    input wire logic [`FLAG_W-1:0] FLAG_STATE,
    input wire logic ALARM_N_I,
    input wire logic ALARM_N_O,
    input wire logic ALARM_N_OE
);
    default clocking cb @(posedge CLK_SYS); endclocking
    default disable iff (RST);
    logic rd_done;
    // Read answered in this cycle
    assign rd_done = AVS_READ && !AVS_WAITREQUEST;
    // ----------------------------------------
    // Bus and register fields
    // ----------------------------------------
    property p_one_wait;
        $rose(AVS_READ) || $rose(AVS_WRITE) |-> AVS_WAITREQUEST ##1 !AVS_WAITREQUEST;
    endproperty
    a_one_wait: assert property (p_one_wait) else $error("wait cycle count wrong");
    property p_echo;
        rd_done && AVS_ADDRESS == 8'h48 |-> AVS_READDATA[20:16] == 5'h12 && AVS_READDATA[31:22] == 10'h0;
    endproperty
    a_echo: assert property (p_echo) else $error("mask word fixed fields wrong");
    property p_unmapped;
        rd_done && AVS_ADDRESS == 8'h40 |-> AVS_READDATA == 32'h0;
    endproperty
    a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
    // Pin must be steady for the synchroniser depth before bit 21 is judged
    property p_pin_status;
        rd_done && $stable(ALARM_N_I) && $past(ALARM_N_I, 3) == ALARM_N_I
            && $past(ALARM_N_I, 2) == ALARM_N_I |-> AVS_READDATA[21] == !ALARM_N_I;
    endproperty
    a_pin_status: assert property (p_pin_status) else $error("pin status bit wrong");
    // ----------------------------------------
    // Flags and alarm pin
    // ----------------------------------------
    property p_flag_set;
        (FLAG_SET & 16'hFFDF) != 16'h0 |=>
            (FLAG_STATE & $past(FLAG_SET) & 16'hFFDF) == ($past(FLAG_SET) & 16'hFFDF);
    endproperty
    a_flag_set: assert property (p_flag_set) else $error("flag not latched");
    property p_rsvd_flag;
        !FLAG_STATE[5];
    endproperty
    a_rsvd_flag: assert property (p_rsvd_flag) else $error("reserved flag set");
    property p_oe_cause;
        $rose(ALARM_N_OE) |-> $past(FLAG_STATE) != 16'h0;
    endproperty
    a_oe_cause: assert property (p_oe_cause) else $error("alarm without flag");
    property p_oe_quiet;
        FLAG_STATE == 16'h0 |=> !ALARM_N_OE;
    endproperty
    a_oe_quiet: assert property (p_oe_quiet) else $error("alarm held with no flags");
    property p_open_drain;
        ALARM_N_O == 1'b0;
    endproperty
    a_open_drain: assert property (p_open_drain) else $error("pin driven high");
endmodule

// ==== alarm_host_model.sv ====
// Purpose: Host side of the alarm wire, open drain with pull-up
// Assumes: Host may also pull the wire low itself
// Notes:   Released wire goes to the pull-up level
`timescale 1ns/100ps
module alarm_host_model (
    input wire logic pin_o,
    input wire logic pin_oe,
    input wire logic ext_low,
    output logic pin_level
);
    // Wired-AND of device and host pull-downs
    assign pin_level = ((pin_oe && !pin_o) || ext_low) ? 1'b0 : 1'b1;
endmodule

// ==== tb.sv ====
// Purpose: Self-checking bench of the alarm mask bank
// Assumes: Avalon-MM master with one request at a time
// Notes:   Pin readback is given four idle edges to settle
`timescale 1ns/100ps
module tb;
    logic CLK_SYS = 1'b0;
    logic RST = 1'b1;
    logic [7:0] addr = 8'h00;
    logic rd = 1'b0;
    logic wr = 1'b0;
    logic [31:0] wdat = 32'h0;
    logic [3:0] ben = 4'hF;
    logic [31:0] rdat;
    logic waitreq;
    logic [15:0] fset = 16'h0;
    logic [15:0] fstate;
    logic pin_o;
    logic pin_oe;
    logic pin;
    logic ext_low = 1'b0;
    logic [31:0] got;
    int fails = 0;
    int num_checks = 0;
    int cycles = 0;
    alarm_pin_mask_control uut (.CLK_SYS(CLK_SYS), .RST(RST), .AVS_ADDRESS(addr),
        .AVS_READ(rd), .AVS_WRITE(wr), .AVS_WRITEDATA(wdat), .AVS_BYTEENABLE(ben),
        .AVS_READDATA(rdat), .AVS_WAITREQUEST(waitreq), .FLAG_SET(fset),
        .FLAG_STATE(fstate), .ALARM_N_I(pin), .ALARM_N_O(pin_o), .ALARM_N_OE(pin_oe));
    alarm_host_model hm (.pin_o(pin_o), .pin_oe(pin_oe), .ext_low(ext_low), .pin_level(pin));
    // Clock and hang guard
    always #50 CLK_SYS = ~CLK_SYS;
    always @(posedge CLK_SYS) begin
        cycles++;
        if (cycles == 3000) begin
            fails++;
            report_and_stop();
        end
    end
    // ----------------------------------------
    // Shared tasks
    // ----------------------------------------
    task report_and_stop;
        if (fails == 0 && num_checks > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask
    task chk(input logic [31:0] g, input logic [31:0] e);
        num_checks++;
        if (g !== e) begin
            fails++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask
    // Request held until waitrequest is sampled low at a rising edge; data taken there
    task bus(input logic w, input logic [7:0] a, input logic [31:0] d, input logic [3:0] be);
        @(posedge CLK_SYS);
        addr <= a;
        wdat <= d;
        ben <= be;
        wr <= w;
        rd <= !w;
        do @(posedge CLK_SYS); while (waitreq !== 1'b0);
        got = rdat;
        wr <= 1'b0;
        rd <= 1'b0;
    endtask
    task rdc(input logic [7:0] a, input logic [31:0] e);
        bus(1'b0, a, 32'h0, 4'hF);
        chk(got, e);
    endtask
    task pulse(input logic [15:0] v);
        @(posedge CLK_SYS);
        fset <= v;
        @(posedge CLK_SYS);
        fset <= 16'h0;
        repeat (4) @(posedge CLK_SYS);
    endtask
    // ----------------------------------------
    // Scenarios
    // ----------------------------------------
    task t_reset_pin;
        rdc(8'h48, 32'h00120000);
        rdc(8'h70, 32'h001C0000);
        rdc(8'h74, 32'h001D0000);
        ext_low <= 1'b1;
        repeat (4) @(posedge CLK_SYS);
        rdc(8'h48, 32'h00320000);
        ext_low <= 1'b0;
        repeat (4) @(posedge CLK_SYS);
        rdc(8'h48, 32'h00120000);
    endtask
    // Each mask bit except reserved bit 5 keeps its own flag off the pin; unmasking lets it drive the pin again
    task t_masks;
        for (int i = 0; i < 16; i++) begin
            if (i != 5) begin
                bus(1'b1, 8'h48, 32'h1 << i, 4'hF);
                pulse(16'h1 << i);
                chk(32'(pin_oe), 32'h0);
                chk(32'(fstate), 32'h1 << i);
                bus(1'b1, 8'h48, 32'h0, 4'hF);
                repeat (4) @(posedge CLK_SYS);
                chk(32'(pin_oe), 32'h1);
                rdc(8'h48, 32'h00320000);
                bus(1'b1, 8'h74, 32'h1 << i, 4'hF);
                repeat (4) @(posedge CLK_SYS);
                chk(32'(pin_oe), 32'h0);
            end
        end
    endtask
    task t_fields;
        bus(1'b1, 8'h48, 32'hFFFFFFDF, 4'hF);
        rdc(8'h48, 32'h0012FFDF);
        bus(1'b1, 8'h48, 32'h0, 4'h2);
        rdc(8'h48, 32'h001200DF);
        pulse(16'h0020);
        chk(32'(fstate), 32'h0);
        bus(1'b1, 8'h40, 32'hFFFF, 4'hF);
        rdc(8'h40, 32'h0);
        bus(1'b1, 8'h48, 32'h0, 4'hF);
        rdc(8'h48, 32'h00120000);
    endtask
    // Locked mask write is dropped and raises the lock flag
    task t_lock;
        bus(1'b1, 8'h70, 32'h3, 4'hF);
        bus(1'b1, 8'h48, 32'hFFDF, 4'hF);
        repeat (3) @(posedge CLK_SYS);
        rdc(8'h48, 32'h00320000);
        chk(32'(fstate), 32'h2000);
        chk(32'(pin_oe), 32'h1);
        bus(1'b1, 8'h70, 32'h0, 4'hF);
        bus(1'b1, 8'h74, 32'hFFFF, 4'hF);
        repeat (4) @(posedge CLK_SYS);
        chk(32'(pin_oe), 32'h0);
        // Lock alone still drops the mask write but raises no flag
        bus(1'b1, 8'h70, 32'h2, 4'hF);
        bus(1'b1, 8'h48, 32'h0001, 4'hF);
        rdc(8'h48, 32'h00120000);
        chk(32'(fstate), 32'h0);
        bus(1'b1, 8'h70, 32'h0, 4'hF);
        // A set input high in the clear cycle keeps the flag
        fset <= 16'h0001;
        bus(1'b1, 8'h74, 32'h1, 4'hF);
        fset <= 16'h0000;
        repeat (2) @(posedge CLK_SYS);
        chk(32'(fstate), 32'h1);
        bus(1'b1, 8'h74, 32'h1, 4'hF);
        repeat (2) @(posedge CLK_SYS);
        chk(32'(fstate), 32'h0);
    endtask
    // Main sequence
    initial begin
        repeat (20) @(posedge CLK_SYS);
        RST <= 1'b0;
        t_reset_pin();
        t_masks();
        t_fields();
        t_lock();
        report_and_stop();
    end
endmodule
bind alarm_pin_mask_control alarm_mask_sva chk_i (.CLK_SYS(CLK_SYS), .RST(RST),
    .AVS_ADDRESS(AVS_ADDRESS), .AVS_READ(AVS_READ), .AVS_WRITE(AVS_WRITE),
    .AVS_READDATA(AVS_READDATA), .AVS_WAITREQUEST(AVS_WAITREQUEST), .FLAG_SET(FLAG_SET),
    .FLAG_STATE(FLAG_STATE), .ALARM_N_I(ALARM_N_I), .ALARM_N_O(ALARM_N_O),
    .ALARM_N_OE(ALARM_N_OE));
